// >>> logic/tfc_defines.svh
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH

// ***********************
// register offsets
// ***********************
`define TFC_OFF_DEFER   12'h000
`define TFC_OFF_FEAT    12'h004

// ***********************
// field positions
// ***********************
`define TFC_B_2PD       4
`define TFC_B_BACKOFF   3
`define TFC_B_TEST      15
`define TFC_B_BURST     14
`define TFC_B_TIMER     13
`define TFC_B_POLL      12
`define TFC_B_PAD       11
`define TFC_B_STRIP     10
`define TFC_B_MISSED_COUNT_OVF      9
`define TFC_B_MISSED_COUNT_OVF_MASK     8
`define TFC_B_RXCO      5
`define TFC_B_RXCOM     4
`define TFC_B_TXS       3
`define TFC_B_TXSM      2
`define TFC_B_JAB       1
`define TFC_B_JABBER_ERR_MASK      0

// ***********************
// reset values, constants
// ***********************
`define TFC_DEFER_RST   2'h0
`define TFC_CTL_RST     6'h00
`define TFC_STAT_RST    4'h0
`define TFC_MASK_RST    4'hf
`define TFC_PAD_MIN     7'h40
`define TFC_PAD_NONE    7'h00

`endif

// >>> logic/tfc_pkg.sv
package tfc_pkg;

    // deferral control outputs
    typedef struct packed {
        logic two_part_deferral_off;
        logic alt_backoff_en;
    } tfc_defer_t;

    // features control outputs
    typedef struct packed {
        logic test_mode_en;
        logic burst_counter_off;
        logic bus_timer_en;
        logic tx_poll_off;
        logic tx_auto_pad;
        logic rx_auto_strip;
    } tfc_feat_t;

    // one-cycle event pulses from the datapath
    typedef struct packed {
        logic missed_count_ovf;
        logic rx_collision_ovf;
        logic tx_started;
        logic jabber_err;
    } tfc_evt_t;

endpackage

// >>> logic/tfc_test_features_control_reg.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "tfc_defines.svh"

module tfc_test_features_control_reg
    import tfc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              stop_cmd,
    input  wire logic              tx_crc_off,
    input  wire logic              transmitter_on,
    input  wire logic              tx_demand,
    input  wire logic              tp_mode,
    input  wire logic              global_irq_en,
    input  wire tfc_evt_t          evt,
    output var  tfc_defer_t        defer,
    output var  tfc_feat_t         feat,
    output var  logic              test_reg_wr_en,
    output var  logic              tx_poll_auto_en,
    output var  logic              tx_poll_manual_en,
    output var  logic              tx_crc_gen_en,
    output var  logic              tx_crc_over_pad,
    output var  logic [6:0]        tx_pad_min,
    output var  logic              irq_summary_flag,
    output var  logic              irq_req
);

    // ***********************
    // parameter check
    // ***********************
    if (ADDR_W < 3) begin : g_bad_addr
        $error("ADDR_W too small for register map");
    end

    // ***********************
    // storage
    // ***********************
    tfc_defer_t  defer_q;
    tfc_defer_t  defer_d;
    tfc_feat_t   ctl_q;
    tfc_feat_t   ctl_d;
    logic [3:0]  stat_q;
    logic [3:0]  stat_d;
    logic [3:0]  mask_q;
    logic [3:0]  mask_d;
    logic        first_q;
    logic        first_d;
    logic [31:0] prdata_q;
    logic        irq_sum_q;
    logic        irq_req_q;
    logic        test_wr_q;
    logic        poll_auto_q;
    logic        poll_man_q;
    logic        crc_gen_q;
    logic        crc_pad_q;
    logic [6:0]  pad_min_q;

    // ***********************
    // flag update helper
    // ***********************
    // set beats clear in the same cycle
    function automatic logic flag_next(
        input logic q,
        input logic set,
        input logic clr
    );
        flag_next = set | (q & ~clr);
    endfunction

    // ***********************
    // apb decode
    // ***********************
    wire hit_defer = paddr == ADDR_W'(`TFC_OFF_DEFER);
    wire hit_feat  = paddr == ADDR_W'(`TFC_OFF_FEAT);
    wire hit       = hit_defer | hit_feat;
    wire access    = psel & penable;
    wire wr        = access & pwrite;
    wire wr_defer  = wr & hit_defer;
    wire wr_feat   = wr & hit_feat;
    wire rd_setup  = psel & ~penable & ~pwrite;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    // ***********************
    // read data
    // ***********************
    // reserved bits read as zero
    wire [15:0] defer_rd = {11'h000,
                            defer_q.two_part_deferral_off,
                            defer_q.alt_backoff_en,
                            3'h0};
    wire [15:0] feat_rd  = {ctl_q.test_mode_en,
                            ctl_q.burst_counter_off,
                            ctl_q.bus_timer_en,
                            ctl_q.tx_poll_off,
                            ctl_q.tx_auto_pad,
                            ctl_q.rx_auto_strip,
                            stat_q[3], mask_q[3],
                            2'h0,
                            stat_q[2], mask_q[2],
                            stat_q[1], mask_q[1],
                            stat_q[0], mask_q[0]};
    wire [31:0] rd_mux = hit_defer ? {16'h0000, defer_rd} :
                         hit_feat  ? {16'h0000, feat_rd}  :
                                     32'h0000_0000;

    // ***********************
    // deferral control
    // ***********************
    // stop does not touch these
    always_comb begin
        defer_d = defer_q;
        if (wr_defer) begin
            defer_d.two_part_deferral_off = pwdata[`TFC_B_2PD];
            defer_d.alt_backoff_en        = pwdata[`TFC_B_BACKOFF];
        end
    end

    // ***********************
    // features control
    // ***********************
    // test mode: one only on first write, zero sticks
    wire test_next = ctl_q.test_mode_en ? pwdata[`TFC_B_TEST]
                                        : (~first_q & pwdata[`TFC_B_TEST]);

    always_comb begin
        ctl_d   = ctl_q;
        first_d = first_q | wr_feat;
        if (wr_feat) begin
            ctl_d.test_mode_en      = test_next;
            ctl_d.burst_counter_off = pwdata[`TFC_B_BURST];
            ctl_d.bus_timer_en      = pwdata[`TFC_B_TIMER];
            ctl_d.tx_poll_off       = pwdata[`TFC_B_POLL];
            ctl_d.tx_auto_pad       = pwdata[`TFC_B_PAD];
            ctl_d.rx_auto_strip     = pwdata[`TFC_B_STRIP];
        end
    end

    // masks ignore stop
    always_comb begin
        mask_d = mask_q;
        if (wr_feat) begin
            mask_d = {pwdata[`TFC_B_MISSED_COUNT_OVF_MASK], pwdata[`TFC_B_RXCOM],
                      pwdata[`TFC_B_TXSM],  pwdata[`TFC_B_JABBER_ERR_MASK]};
        end
    end

    // ***********************
    // status flags
    // ***********************
    // jabber only counts in twisted pair mode
    wire [3:0] st_set = {evt.missed_count_ovf,
                         evt.rx_collision_ovf,
                         evt.tx_started,
                         evt.jabber_err & tp_mode};
    wire [3:0] st_w1c = {pwdata[`TFC_B_MISSED_COUNT_OVF], pwdata[`TFC_B_RXCO],
                         pwdata[`TFC_B_TXS],  pwdata[`TFC_B_JAB]};
    wire [3:0] st_clr = {4{stop_cmd}} | ({4{wr_feat}} & st_w1c);

    assign stat_d[3] = flag_next(stat_q[3], st_set[3], st_clr[3]);
    assign stat_d[2] = flag_next(stat_q[2], st_set[2], st_clr[2]);
    assign stat_d[1] = flag_next(stat_q[1], st_set[1], st_clr[1]);
    assign stat_d[0] = flag_next(stat_q[0], st_set[0], st_clr[0]);

    // ***********************
    // interrupt summary
    // ***********************
    wire irq_sum_d = |(stat_d & ~mask_d);
    wire irq_req_d = global_irq_en & irq_sum_d;

    // ***********************
    // derived controls
    // ***********************
    wire test_wr_d   = ctl_q.test_mode_en;
    wire poll_auto_d = ~ctl_q.tx_poll_off & transmitter_on;
    wire poll_man_d  = tx_demand & transmitter_on;
    wire crc_gen_d   = ctl_q.tx_auto_pad | ~tx_crc_off;
    wire crc_pad_d   = ctl_q.tx_auto_pad;
    wire [6:0] pad_min_d = ctl_q.tx_auto_pad ? `TFC_PAD_MIN
                                             : `TFC_PAD_NONE;

    // ***********************
    // registers
    // ***********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            defer_q <= `TFC_DEFER_RST;
            ctl_q   <= `TFC_CTL_RST;
            stat_q  <= `TFC_STAT_RST;
            mask_q  <= `TFC_MASK_RST;
            first_q <= 1'b0;
        end else begin
            defer_q <= defer_d;
            ctl_q   <= ctl_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            first_q <= first_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sum_q <= 1'b0;
            irq_req_q <= 1'b0;
        end else begin
            irq_sum_q <= irq_sum_d;
            irq_req_q <= irq_req_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_wr_q   <= 1'b0;
            poll_auto_q <= 1'b0;
            poll_man_q  <= 1'b0;
            crc_gen_q   <= 1'b0;
            crc_pad_q   <= 1'b0;
            pad_min_q   <= `TFC_PAD_NONE;
        end else begin
            test_wr_q   <= test_wr_d;
            poll_auto_q <= poll_auto_d;
            poll_man_q  <= poll_man_d;
            crc_gen_q   <= crc_gen_d;
            crc_pad_q   <= crc_pad_d;
            pad_min_q   <= pad_min_d;
        end
    end

    // ***********************
    // outputs
    // ***********************
    assign prdata            = prdata_q;
    assign defer             = defer_q;
    assign feat              = ctl_q;
    assign test_reg_wr_en    = test_wr_q;
    assign tx_poll_auto_en   = poll_auto_q;
    assign tx_poll_manual_en = poll_man_q;
    assign tx_crc_gen_en     = crc_gen_q;
    assign tx_crc_over_pad   = crc_pad_q;
    assign tx_pad_min        = pad_min_q;
    assign irq_summary_flag  = irq_sum_q;
    assign irq_req           = irq_req_q;

    // ***********************
    // assertions
    // ***********************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_zero_written;
        wr_feat && !pwdata[`TFC_B_TEST];
    endsequence

    sequence s_one_tried;
        wr_feat && pwdata[`TFC_B_TEST];
    endsequence

    sequence s_first_write;
        wr_feat && !first_q;
    endsequence

    test_lock_a: assert property (
        s_zero_written |=> !feat.test_mode_en
    ) else $error("test mode set after zero written");

    test_set_a: assert property (
        s_first_write ##0 s_one_tried |=> feat.test_mode_en
    ) else $error("test mode not set by first write");

    test_late_a: assert property (
        $rose(feat.test_mode_en) |-> $past(wr_feat && !first_q)
    ) else $error("test mode set on a later write");

    test_wr_a: assert property (
        test_reg_wr_en == $past(feat.test_mode_en)
    ) else $error("test write permit not following test mode");

    poll_off_a: assert property (
        (tx_poll_auto_en || tx_poll_manual_en) |-> $past(transmitter_on)
    ) else $error("poll allowed while transmitter off");

    crc_pad_a: assert property (
        $past(feat.tx_auto_pad) |-> tx_crc_gen_en
    ) else $error("crc disabled while auto pad on");

    missed_count_ovf_stop_a: assert property (
        stop_cmd && !evt.missed_count_ovf |=> !stat_q[3]
    ) else $error("missed overflow flag kept after stop");

    rxco_set_a: assert property (
        evt.rx_collision_ovf |=> stat_q[2] ##1 (stat_q[2] || $past(st_clr[2]))
    ) else $error("collision overflow flag not held");

    txs_w1c_a: assert property (
        wr_feat && pwdata[`TFC_B_TXS] && !evt.tx_started |=> !stat_q[1]
    ) else $error("tx start flag not cleared by write one");

    txs_irq_a: assert property (
        stat_q[1] && !mask_q[1] && $past(global_irq_en) |-> irq_req
    ) else $error("irq missing for tx start");

    jab_mode_a: assert property (
        $rose(stat_q[0]) |-> $past(evt.jabber_err && tp_mode)
    ) else $error("jabber set outside twisted pair");

    jab_w1c_a: assert property (
        wr_feat && pwdata[`TFC_B_JAB] && !(evt.jabber_err && tp_mode)
        |=> !stat_q[0]
    ) else $error("jabber not cleared by write one");

    mask_stop_a: assert property (
        stop_cmd && !wr_feat |=> mask_q == $past(mask_q)
    ) else $error("mask changed by stop");

    irq_sum_a: assert property (
        irq_summary_flag == |(stat_q & ~mask_q)
    ) else $error("summary flag mismatch");

    defer_stop_a: assert property (
        stop_cmd && !wr_defer |=> defer == $past(defer)
    ) else $error("deferral control changed by stop");

    backoff_wr_a: assert property (
        wr_defer |=> defer.alt_backoff_en == $past(pwdata[`TFC_B_BACKOFF])
    ) else $error("back-off enable not written");

    burst_wr_a: assert property (
        wr_feat |=> feat.burst_counter_off == $past(pwdata[`TFC_B_BURST])
    ) else $error("burst counter off not written");

    timer_wr_a: assert property (
        wr_feat |=> feat.bus_timer_en == $past(pwdata[`TFC_B_TIMER])
    ) else $error("bus timer enable not written");

    poll_wr_a: assert property (
        wr_feat |=> feat.tx_poll_off == $past(pwdata[`TFC_B_POLL])
    ) else $error("poll disable not written");

    pad_min_a: assert property (
        tx_pad_min == ($past(feat.tx_auto_pad) ? `TFC_PAD_MIN : `TFC_PAD_NONE)
    ) else $error("pad length not following auto pad");

    crc_over_a: assert property (
        tx_crc_over_pad == $past(feat.tx_auto_pad)
    ) else $error("crc over pad not following auto pad");

    strip_wr_a: assert property (
        wr_feat |=> feat.rx_auto_strip == $past(pwdata[`TFC_B_STRIP])
    ) else $error("auto strip not written");

    resv_zero_a: assert property (
        rd_setup |=> prdata[7:6] == 2'h0 && prdata[31:16] == 16'h0000
    ) else $error("reserved bits read nonzero");

    ovf_mask_a: assert property (
        mask_q[3] && mask_q[2] && !stat_q[1] && !stat_q[0] |-> !irq_summary_flag
    ) else $error("masked overflow raised summary");

    txj_mask_a: assert property (
        mask_q[1] && mask_q[0] && !stat_q[3] && !stat_q[2] |-> !irq_summary_flag
    ) else $error("masked tx start or jabber raised summary");

endmodule

`default_nettype wire

// >>> sim/tb_test_features_control_reg.sv
`timescale 1ns/1ns
`default_nettype none
`include "tfc_defines.svh"

module tb_test_features_control_reg;
    import tfc_pkg::*;

    localparam logic [11:0] A_DEF  = `TFC_OFF_DEFER;
    localparam logic [11:0] A_FEAT = `TFC_OFF_FEAT;
    localparam logic [31:0] FRST   = 32'h0000_0115;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        stop_cmd;
    logic        tx_crc_off;
    logic        transmitter_on;
    logic        tx_demand;
    logic        tp_mode;
    logic        global_irq_en;
    tfc_evt_t    evt;
    tfc_defer_t  defer;
    tfc_feat_t   feat;
    logic        test_reg_wr_en;
    logic        tx_poll_auto_en;
    logic        tx_poll_manual_en;
    logic        tx_crc_gen_en;
    logic        tx_crc_over_pad;
    logic [6:0]  tx_pad_min;
    logic        irq_summary_flag;
    logic        irq_req;
    int          n_mismatch;
    int          checks_done;
    int          bp [4] = '{`TFC_B_MISSED_COUNT_OVF, `TFC_B_RXCO, `TFC_B_TXS, `TFC_B_JAB};

    always #5 pclk = ~pclk;

    tfc_host_model u_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    tfc_test_features_control_reg u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_cmd(stop_cmd),
        .tx_crc_off(tx_crc_off), .transmitter_on(transmitter_on),
        .tx_demand(tx_demand), .tp_mode(tp_mode), .global_irq_en(global_irq_en),
        .evt(evt), .defer(defer), .feat(feat), .test_reg_wr_en(test_reg_wr_en),
        .tx_poll_auto_en(tx_poll_auto_en), .tx_poll_manual_en(tx_poll_manual_en),
        .tx_crc_gen_en(tx_crc_gen_en), .tx_crc_over_pad(tx_crc_over_pad),
        .tx_pad_min(tx_pad_min), .irq_summary_flag(irq_summary_flag), .irq_req(irq_req)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic err);
        bit to;
        u_host.xfer(1'b0, a, 32'h0000_0000, q, err, to);
        if (to) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        err;
        bit          to;
        u_host.xfer(1'b1, a, d, q, err, to);
        if (to) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic        err;
        rd(a, q, err);
        chk("rdata", e, q);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic pulse(input tfc_evt_t v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= 4'h0;
    endtask

    task automatic stop_pulse();
        @(posedge pclk);
        stop_cmd <= 1'b1;
        @(posedge pclk);
        stop_cmd <= 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rdc(A_DEF, 32'h0000_0000);
        rdc(A_FEAT, FRST);
        chk("feat", 32'h0, 32'(feat));
    endtask

    task automatic t_test_mode();
        wr(A_FEAT, FRST | 32'h8000);
        settle(0);
        chk("test_mode_en", 32'h1, 32'(feat.test_mode_en));
        settle(1);
        chk("test_reg_wr_en", 32'h1, 32'(test_reg_wr_en));
        wr(A_FEAT, FRST);
        wr(A_FEAT, FRST | 32'h8000);
        settle(1);
        chk("test_mode_en", 32'h0, 32'(feat.test_mode_en));
        do_reset();
        settle(0);
        chk("test_mode_en", 32'h0, 32'(feat.test_mode_en));
        wr(A_FEAT, FRST);
        wr(A_FEAT, FRST | 32'h8000);
        rdc(A_FEAT, FRST);
    endtask

    task automatic t_ctrl();
        for (int b = 10; b < 15; b++) begin
            wr(A_FEAT, FRST | (32'h1 << b));
            rdc(A_FEAT, FRST | (32'h1 << b));
            chk("feat", 32'h1 << (b - 10), 32'(feat));
        end
        // reserved positions written as zero
        wr(A_FEAT, 32'h0000_7d15);
        rdc(A_FEAT, 32'h0000_7d15);
        wr(A_DEF, 32'h0000_0018);
        rdc(A_DEF, 32'h0000_0018);
        chk("defer", 32'h3, 32'(defer));
        stop_pulse();
        rdc(A_DEF, 32'h0000_0018);
        rdc(A_FEAT, 32'h0000_7d15);
    endtask

    task automatic t_derived();
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            transmitter_on <= i[2];
            tx_crc_off     <= i[0];
            tx_demand      <= i[1];
            wr(A_FEAT, FRST | (32'(i[0]) << 12) | (32'(i[1]) << 11));
            settle(1);
            chk("poll_auto", 32'(!i[0] && i[2]), 32'(tx_poll_auto_en));
            chk("poll_manual", 32'(i[1] & i[2]), 32'(tx_poll_manual_en));
            chk("crc_gen", 32'(i[1] || !i[0]), 32'(tx_crc_gen_en));
            chk("crc_over_pad", 32'(i[1]), 32'(tx_crc_over_pad));
            chk("pad_min", i[1] ? 32'h40 : 32'h0, 32'(tx_pad_min));
        end
    endtask

    task automatic t_flags();
        wr(A_FEAT, FRST);
        @(posedge pclk);
        tp_mode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pulse(tfc_evt_t'(4'h8 >> k));
            rdc(A_FEAT, FRST | (32'h1 << bp[k]));
            settle(0);
            chk("summary", 32'h0, 32'(irq_summary_flag));
            wr(A_FEAT, FRST);
            rdc(A_FEAT, FRST | (32'h1 << bp[k]));
            wr(A_FEAT, FRST | (32'h1 << bp[k]));
            rdc(A_FEAT, FRST);
        end
        @(posedge pclk);
        tp_mode <= 1'b0;
        pulse(tfc_evt_t'(4'h1));
        rdc(A_FEAT, FRST);
    endtask

    task automatic t_irq();
        wr(A_FEAT, 32'h0000_0000);
        @(posedge pclk);
        global_irq_en <= 1'b1;
        tp_mode       <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            if (k == 4) begin
                @(posedge pclk);
                global_irq_en <= 1'b0;
            end
            pulse(tfc_evt_t'(4'h8 >> (k % 4)));
            settle(1);
            chk("summary", 32'h1, 32'(irq_summary_flag));
            chk("irq_req", (k < 4) ? 32'h1 : 32'h0, 32'(irq_req));
            stop_pulse();
            settle(1);
            chk("summary", 32'h0, 32'(irq_summary_flag));
        end
        rdc(A_FEAT, 32'h0000_0000);
    endtask

    task automatic t_unmapped();
        logic [31:0] q;
        logic        err;
        rd(12'h008, q, err);
        chk("unmapped rdata", 32'h0, q);
        chk("pslverr", 32'h1, 32'(err));
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        pclk           = 1'b0;
        presetn        = 1'b0;
        stop_cmd       = 1'b0;
        tx_crc_off     = 1'b0;
        transmitter_on = 1'b0;
        tx_demand      = 1'b0;
        tp_mode        = 1'b0;
        global_irq_en  = 1'b0;
        evt            = 4'h0;
        n_mismatch     = 0;
        checks_done    = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_test_mode();
        t_ctrl();
        t_derived();
        t_flags();
        t_irq();
        t_unmapped();
        end_sim();
    end
endmodule

`default_nettype wire

// >>> sim/tfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// host side of the register port
// ****************************************
module tfc_host_model (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // one transfer; request held until pready seen high at an edge, or for at most 50 edges
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output bit to);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wr ? d : 32'h0000_0000;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q        = prdata;
        err      = pslverr;
        to       = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire
